// file: verilog/pxs_top.sv
// Proximity control, I2C target and colour readout in one module.
// Assumes open-drain SCL/SDA pins resolved outside, and colour data in clk_sys domain.
`timescale 1ns/1ps
module pxs_top import pxs_pkg::*; #(
  parameter int CYCLE_CYC = CYCLE_UNIT_CYC  // Clock cycles per cycle-code step
) (
  input wire logic clk_sys,               // System clock, 20 MHz
  input wire logic srst,                  // Synchronous reset, active high
  input wire logic scl_in,                // Serial clock pin level
  input wire logic sda_in,                // Serial data pin level
  output logic sda_out,                   // Serial data drive value
  output logic sda_oe,                    // Serial data drive enable
  input wire pxs_color_t color_data,      // Latest colour results
  input wire logic [7:0] echo_level,      // Reflected light level from the front end
  output logic prox_pulse,                // Red emitter pulse
  output logic [6:0] led_current_ma,      // Emitter current during pulses
  output logic prox_flag                  // Proximity interrupt flag
);
  typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK} pxs_i2c_t;
  typedef enum {PX_IDLE, PX_HIGH, PX_LOW, PX_WAIT} pxs_prox_t;

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d;
  logic sda_d;
  pxs_i2c_t st;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [7:0] ptr;
  logic ptr_pending;
  logic rw;
  pxs_cfg_t cfg;
  pxs_prox_t pst;
  logic [31:0] tmr;
  logic [5:0] pulse_idx;
  logic [5:0] hits;
  logic [7:0] echo_s;
  logic [7:0] echo_q;
  logic [7:0] rd_cur;

  // Two flops on each pin before any logic looks at it
  always_ff @(posedge clk_sys) begin
    scl_sync <= {scl_sync[0], scl_in};
    sda_sync <= {sda_sync[0], sda_in};
    scl_d <= scl_sync[1];
    sda_d <= sda_sync[1];
  end

  // Bus conditions
  wire scl_rise = scl_sync[1] & ~scl_d;
  wire scl_fall = ~scl_sync[1] & scl_d;
  wire start_c = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  wire stop_c = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  wire byte_done = (bit_cnt == 4'h8);
  wire addr_hit = (shreg[7:1] == PXS_I2C_ADDR);  // see RL1
  wire wr_data = (st == ST_WR) & scl_fall & byte_done & ~ptr_pending;

  // Read mux: colour pairs high byte first, blue then infrared last
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    case (a)
      REG_RED_HI: rd_byte = color_data.red[15:8];
      REG_RED_LO: rd_byte = color_data.red[7:0];
      REG_GRN_HI: rd_byte = color_data.green[15:8];
      REG_GRN_LO: rd_byte = color_data.green[7:0];
      REG_BLU_HI: rd_byte = color_data.blue[15:8];  // see RL2
      REG_BLU_LO: rd_byte = color_data.blue[7:0];
      REG_IR_HI: rd_byte = color_data.ir[15:8];
      REG_IR_LO: rd_byte = color_data.ir[7:0];
      REG_PROX_CTRL: rd_byte = {cfg.meas_reset, cfg.sleep, 2'b00, cfg.drive_code};
      REG_PROX_TIMING: rd_byte = {cfg.cycle_code, cfg.pulse_code};
      REG_PROX_THRESH: rd_byte = cfg.threshold;
      REG_PROX_STATUS: rd_byte = {prox_flag, 7'h00};  // see RL9
      default: rd_byte = 8'h00;
    endcase
  endfunction

  // Byte at the pointer; a process, so colour and flag changes are seen too
  always_comb rd_cur = rd_byte(ptr);

  // Target protocol engine: sample on SCL rise, change SDA on SCL fall
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      ptr <= 8'h00;
      ptr_pending <= 1'b0;
      rw <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      // Repeated start keeps the pointer so a read follows a pointer write
      st <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      st <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (st == ST_ADDR || st == ST_WR) begin
        shreg <= {shreg[6:0], sda_sync[1]};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (st == ST_RD) begin
        bit_cnt <= bit_cnt + 4'h1;
      end else if (st == ST_RACK && sda_sync[1]) begin
        st <= ST_IDLE;  // Host NACK ends the burst; stop follows (see RL3)
      end
    end else if (scl_fall) begin
      case (st)
        ST_ADDR: begin
          if (byte_done && addr_hit) begin
            st <= ST_AACK;
            rw <= shreg[0];  // see RL1
            sda_oe <= 1'b1;
          end else if (byte_done) begin
            st <= ST_IDLE;
          end
        end
        ST_AACK: begin
          bit_cnt <= 4'h0;
          if (rw) begin
            st <= ST_RD;
            txreg <= {rd_cur[6:0], 1'b0};
            sda_oe <= ~rd_cur[7];
            ptr <= ptr + 8'h01;
          end else begin
            st <= ST_WR;
            ptr_pending <= 1'b1;
            sda_oe <= 1'b0;
          end
        end
        ST_WR: begin
          if (byte_done) begin
            st <= ST_WACK;
            sda_oe <= 1'b1;
            // First byte is the pointer, later bytes fill consecutive locations
            if (ptr_pending) begin
              ptr <= shreg;
              ptr_pending <= 1'b0;
            end else begin
              ptr <= ptr + 8'h01;  // see RL4
            end
          end
        end
        ST_WACK: begin
          st <= ST_WR;
          bit_cnt <= 4'h0;
          sda_oe <= 1'b0;
        end
        ST_RD: begin
          if (byte_done) begin
            st <= ST_RACK;
            sda_oe <= 1'b0;
          end else begin
            sda_oe <= ~txreg[7];
            txreg <= {txreg[6:0], 1'b0};
          end
        end
        ST_RACK: begin
          // Host acknowledged: stream the next location
          st <= ST_RD;
          bit_cnt <= 4'h0;
          txreg <= {rd_cur[6:0], 1'b0};
          sda_oe <= ~rd_cur[7];
          ptr <= ptr + 8'h01;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Open drain: only ever pull low
  assign sda_out = 1'b0;

  // Configuration writes; only the proximity bytes are writable
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      {cfg.meas_reset, cfg.sleep} <= PROX_CTRL_RST[CTRL_RESET_BIT -: 2];
      cfg.drive_code <= PROX_CTRL_RST[3:0];
      {cfg.cycle_code, cfg.pulse_code} <= PROX_TIMING_RST;
      cfg.threshold <= PROX_THRESH_RST;
    end else if (wr_data) begin
      case (ptr)
        REG_PROX_CTRL: begin
          cfg.meas_reset <= shreg[CTRL_RESET_BIT];  // see RL15, RL8, RL10
          cfg.sleep <= shreg[CTRL_SLEEP_BIT];
          cfg.drive_code <= shreg[3:0];
        end
        REG_PROX_TIMING: {cfg.cycle_code, cfg.pulse_code} <= shreg;  // see RL5, RL16
        REG_PROX_THRESH: cfg.threshold <= shreg;  // see RL7
        default: cfg.threshold <= cfg.threshold;
      endcase
    end
  end

  // Decoded codes; a zero code is taken as one step so a cycle never collapses
  wire [3:0] cyc_code = (cfg.cycle_code == 4'h0) ? 4'h1 : cfg.cycle_code;
  wire [3:0] pls_code = (cfg.pulse_code == 4'h0) ? 4'h1 : cfg.pulse_code;
  wire [5:0] n_pulses = 6'(pls_code * PULSES_PER_CODE);  // see RL13, RL7
  wire [31:0] period_cyc = 32'(cyc_code * CYCLE_CYC);  // see RL7
  wire running = ~cfg.meas_reset & ~cfg.sleep;  // see RL8, RL10
  wire echo_hit = (echo_q >= cfg.threshold);

  // Reflected level arrives from the analog side, so it is synchronised
  always_ff @(posedge clk_sys) begin
    echo_s <= echo_level;
    echo_q <= echo_s;
  end

  // Drive current code scaled to mA, 8 mA per step
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      led_current_ma <= 7'h00;
    end else begin
      led_current_ma <= 7'(cfg.drive_code * MA_PER_CODE);  // see RL6, RL14
    end
  end

  // Measurement sequencer: a burst of pulses at the start of each cycle
  always_ff @(posedge clk_sys) begin
    if (srst || !running) begin
      pst <= PX_IDLE;
      tmr <= 32'h0;
      pulse_idx <= 6'h00;
      hits <= 6'h00;
      prox_pulse <= 1'b0;
      if (srst) begin
        prox_flag <= 1'b0;
      end
    end else begin
      tmr <= tmr + 32'h1;
      case (pst)
        PX_IDLE: begin
          pst <= PX_HIGH;  // see RL11
          tmr <= 32'h0;
          pulse_idx <= 6'h00;
          hits <= 6'h00;
          prox_pulse <= 1'b1;
        end
        PX_HIGH: begin
          if (tmr[15:0] >= 16'(PULSE_HIGH_CYC - 1)) begin
            pst <= PX_LOW;
            prox_pulse <= 1'b0;
            hits <= hits + {5'h00, echo_hit};
            pulse_idx <= pulse_idx + 6'h01;
          end
        end
        PX_LOW: begin
          if (tmr[15:0] >= 16'(2 * PULSE_HIGH_CYC - 1)) begin
            if (pulse_idx == n_pulses) begin
              pst <= PX_WAIT;
              tmr <= 32'h0;  // Wait counts from the end of the burst
              prox_flag <= (hits == n_pulses);  // see RL12
            end else begin
              pst <= PX_HIGH;
              prox_pulse <= 1'b1;
              tmr <= 32'h0;
            end
          end
        end
        PX_WAIT: begin
          // Idle for the whole cycle-code period before the next burst
          if (tmr >= period_cyc - 32'h1) begin
            pst <= PX_IDLE;  // see RL11
          end
        end
        default: pst <= PX_IDLE;
      endcase
    end
  end
endmodule

// file: common/pxs_pkg.sv
// Package for the proximity-sensing control and readout block.
// Assumes a 20 MHz system clock and an I2C host on the serial pins.
// Functional notes
// RL1 - Answer as I2C target 0x2A; write with R/W low, read after repeated start.
// RL2 - Colour burst returns each channel high byte first; blue then infrared last.
// RL3 - Host acknowledges each colour byte but NACKs infrared low, then stops.
// RL4 - Pointer 0x0B plus three bytes stores consecutively; first is sleep/current.
// RL5 - Second configuration byte holds measurement cycle code and pulse count code.
// RL6 - Drive code 0xC means 96 mA red emitter current during pulses.
// RL7 - Cycle code 1 is 64 ms, pulse code 1 is three pulses, threshold 0x20 is 32.
// RL8 - Rewriting 0x0B with 0x0C releases measurement reset so measuring begins.
// RL9 - Proximity interrupt flag is bit 7 of byte 0x10, read by pointer and restart.
// RL10 - Writing 0xCC to 0x0B returns the proximity unit to sleep.
// RL11 - Once released, measurements repeat every cycle until sleep is set.
// RL12 - Flag set to 1 only when every emitted pulse of a measurement was detected.
// RL13 - Pulse counts are multiples of three from 3 to 45.
// RL14 - Drive current 8 mA to 96 mA in 8 mA steps, one step per code; codes 13 to 15 are not limited and give 104 to 120 mA.
// RL15 - Control byte: bit 7 measurement reset, bit 6 sleep, bits 3..0 current code.
// RL16 - Second byte: upper nibble cycle code, lower nibble pulse count code.
package pxs_pkg;
  localparam logic [6:0] PXS_I2C_ADDR = 7'h2a;
  // Register offsets
  localparam logic [7:0] REG_RED_HI = 8'h03;
  localparam logic [7:0] REG_RED_LO = 8'h04;
  localparam logic [7:0] REG_GRN_HI = 8'h05;
  localparam logic [7:0] REG_GRN_LO = 8'h06;
  localparam logic [7:0] REG_BLU_HI = 8'h07;
  localparam logic [7:0] REG_BLU_LO = 8'h08;
  localparam logic [7:0] REG_IR_HI = 8'h09;
  localparam logic [7:0] REG_IR_LO = 8'h0a;
  localparam logic [7:0] REG_PROX_CTRL = 8'h0b;
  localparam logic [7:0] REG_PROX_TIMING = 8'h0c;
  localparam logic [7:0] REG_PROX_THRESH = 8'h0d;
  localparam logic [7:0] REG_PROX_STATUS = 8'h10;
  // Field positions
  localparam int CTRL_RESET_BIT = 7;
  localparam int CTRL_SLEEP_BIT = 6;
  localparam int STATUS_FLAG_BIT = 7;
  // Reset values: unit asleep and held in measurement reset
  localparam logic [7:0] PROX_CTRL_RST = 8'hc0;
  localparam logic [7:0] PROX_TIMING_RST = 8'h11;
  localparam logic [7:0] PROX_THRESH_RST = 8'h00;
  // Scaling of codes
  localparam int PULSES_PER_CODE = 3;
  localparam int MA_PER_CODE = 8;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CYCLE_UNIT_MS = 64;
  localparam int CYCLE_UNIT_CYC = CYCLE_UNIT_MS * (CLK_HZ / 1000);
  localparam int PULSE_HIGH_US = 10;
  localparam int PULSE_HIGH_CYC = (PULSE_HIGH_US * (CLK_HZ / 1000) + 999) / 1000;

  typedef struct packed {
    logic [15:0] red;
    logic [15:0] green;
    logic [15:0] blue;
    logic [15:0] ir;
  } pxs_color_t;

  typedef struct packed {
    logic meas_reset;
    logic sleep;
    logic [3:0] drive_code;
    logic [3:0] cycle_code;
    logic [3:0] pulse_code;
    logic [7:0] threshold;
  } pxs_cfg_t;
endpackage

// file: verif/pxs_chk.sv
// Port-level assertions for the proximity block.
// Assumes it is bound to pxs_top and sees only its ports.
`timescale 1ns/1ps
module pxs_chk import pxs_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic scl_in, // SCL level
  input wire logic sda_in, // SDA level
  input wire logic sda_out, // SDA drive value
  input wire logic sda_oe, // SDA drive enable
  input wire pxs_color_t color_data, // Colour results
  input wire logic [7:0] echo_level, // Echo level
  input wire logic prox_pulse, // Emitter pulse
  input wire logic [6:0] led_current_ma, // Emitter current
  input wire logic prox_flag // Interrupt flag
);
  logic [8:0] hi_cnt;
  logic [8:0] lo_cnt;
  logic [8:0] hi_last;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Run lengths of the pulse; low count saturates so long idle gaps never wrap
  always_ff @(posedge clk_sys) begin
    hi_cnt <= (srst || !prox_pulse) ? 9'h000 : hi_cnt + 9'h001;
    lo_cnt <= (srst || prox_pulse) ? (srst ? 9'h1ff : 9'h000) : lo_cnt + {8'h00, ~&lo_cnt};
    // Length of the last high run; a stop may legally cut the final pulse short
    hi_last <= srst ? 9'h000 : ((!prox_pulse && hi_cnt != 9'h000) ? hi_cnt : hi_last);
  end
  property p_rst;
    disable iff (1'b0) srst |=> !sda_oe && !prox_flag && !prox_pulse && led_current_ma == 7'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_idle;
    $fell(srst) |-> !prox_pulse [*8];
  endproperty
  a_idle: assert property (p_idle) else $error("pulse while asleep");
  property p_sda;
    sda_out == 1'b0;
  endproperty
  a_sda: assert property (p_sda) else $error("SDA driven high");
  property p_oe;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("SDA changed while SCL high");
  property p_cur;
    led_current_ma[2:0] == 3'h0 && led_current_ma <= 7'h60;
  endproperty
  a_cur: assert property (p_cur) else $error("current off the 8 mA grid");
  property p_pw;
    $fell(prox_pulse) |-> hi_cnt <= PULSE_HIGH_CYC;
  endproperty
  a_pw: assert property (p_pw) else $error("pulse longer than its width");
  property p_pwx;
    $rose(prox_pulse) && lo_cnt == PULSE_HIGH_CYC |-> hi_last == PULSE_HIGH_CYC;
  endproperty
  a_pwx: assert property (p_pwx) else $error("pulse inside a burst has wrong width");
  property p_gap;
    $rose(prox_pulse) |-> lo_cnt >= PULSE_HIGH_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("pulse gap too short");
  property p_flag;
    $changed(prox_flag) && !$past(srst) |-> !prox_pulse && !$past(prox_pulse);
  endproperty
  a_flag: assert property (p_flag) else $error("flag moved inside a pulse");
  c_set: cover property ($rose(prox_flag));
  c_clr: cover property ($fell(prox_flag));
  c_ack: cover property ($rose(sda_oe));
endmodule

// file: verif/pxs_host.sv
// Behavioural I2C host that the bench steers through its tasks.
// Assumes SDA has a pull-up and that the target never stretches SCL.
`timescale 1ns/1ps
module pxs_host (
  input wire logic clk_sys, // Bench clock, paces the bus
  input wire logic sda_oe, // Target pulls SDA low
  output logic scl_in, // Resolved SCL
  output logic sda_in // Resolved SDA
);
  logic scl_h = 1'b1;
  logic sda_h = 1'b1;
  // SDA is the wired-AND of both parties and floats to the pull-up when released; SCL is the host's alone
  assign scl_in = scl_h;
  assign sda_in = sda_h & ~sda_oe;
  task automatic hw(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Data moves mid-low, sampled mid-high, well clear of the target's sync delay
  task automatic bit_io(input logic b, output logic r);
    sda_h <= b;
    hw(8);
    scl_h <= 1'b1;
    hw(8);
    r = sda_in;
    hw(8);
    scl_h <= 1'b0;
    hw(8);
  endtask
  task automatic start();
    sda_h <= 1'b1;
    hw(8);
    scl_h <= 1'b1;
    hw(8);
    sda_h <= 1'b0;
    hw(8);
    scl_h <= 1'b0;
    hw(8);
  endtask
  task automatic stop();
    sda_h <= 1'b0;
    hw(8);
    scl_h <= 1'b1;
    hw(8);
    sda_h <= 1'b1;
    hw(8);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Last byte of a read is refused so the target lets go of SDA
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// file: verif/pxs_top_test.sv
// Self-checking bench for pxs_top with an I2C host model.
// Assumes a short measurement cycle so bursts repeat quickly.
`timescale 1ns/1ps
module pxs_top_test import pxs_pkg::*;;
  localparam int CYC = 500;
  localparam int PER = 2 * PULSE_HIGH_CYC;
  logic clk_sys = 1'b0;
  logic srst;
  logic scl_in;
  logic sda_in;
  logic sda_out;
  logic sda_oe;
  pxs_color_t color_data;
  logic [7:0] echo_level;
  logic prox_pulse;
  logic [6:0] led_current_ma;
  logic prox_flag;
  logic pulse_d = 1'b0;
  logic [7:0] q[$];
  logic [6:0] bad;
  logic [3:0] dc;
  logic [3:0] pc;
  logic a;
  int fails;
  int n_compared;
  int npulse;
  int cyc = 0;
  integer seed;
  always #25 clk_sys = ~clk_sys;
  pxs_top #(.CYCLE_CYC(CYC)) dut (.clk_sys(clk_sys), .srst(srst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .color_data(color_data),
    .echo_level(echo_level), .prox_pulse(prox_pulse), .led_current_ma(led_current_ma),
    .prox_flag(prox_flag));
  pxs_host h (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));
  task automatic finish_test();
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write up to three bytes from pointer p; the stop is optional so Sr can follow
  task automatic wr(input logic [7:0] p, input logic [23:0] d, input int n, input logic stp);
    logic ak;
    h.start();
    h.wbyte({PXS_I2C_ADDR, 1'b0}, ak);
    chk("addr ack", {7'h0, ak}, 8'h01);
    h.wbyte(p, ak);
    chk("ptr ack", {7'h0, ak}, 8'h01);
    for (int i = 0; i < n; i++) begin
      h.wbyte(d[23 - 8 * i -: 8], ak);
      chk("data ack", {7'h0, ak}, 8'h01);
    end
    if (stp) h.stop();
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    logic ak;
    logic [7:0] b;
    wr(p, 24'h0, 0, 1'b0);
    h.start();
    h.wbyte({PXS_I2C_ADDR, 1'b1}, ak);
    chk("read ack", {7'h0, ak}, 8'h01);
    q.delete();
    for (int i = 0; i < n; i++) begin
      h.rbyte(i == n - 1, b);
      q.push_back(b);
    end
    h.stop();
  endtask
  // Rising edges of the emitter pulse, cleared by the main sequence
  always @(posedge clk_sys) begin
    pulse_d <= prox_pulse;
    if (prox_pulse && !pulse_d) npulse++;
    cyc++;
    if (cyc == 95000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    seed = 91;
    srst = 1'b1;
    echo_level = 8'h00;
    color_data = '0;
    fails = 0;
    n_compared = 0;
    npulse = 0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    color_data <= {$random(seed), $random(seed)};
    bad = 7'($random(seed));
    if (bad == PXS_I2C_ADDR) bad = 7'h15;
    rd(REG_PROX_CTRL, 3);
    chk("ctrl", q[0], PROX_CTRL_RST);
    chk("timing", q[1], PROX_TIMING_RST);
    chk("thresh", q[2], PROX_THRESH_RST);
    // Unmapped gap then status, all zero out of reset
    rd(8'h0e, 3);
    foreach (q[i]) chk("unmapped", q[i], 8'h00);
    h.start();
    h.wbyte({bad, 1'b0}, a);
    h.stop();
    chk("foreign ack", {7'h0, a}, 8'h00);
    // Start sequence with the echo exactly at threshold
    echo_level <= 8'h20;
    wr(REG_PROX_CTRL, 24'h8c1120, 3, 1'b0);
    npulse = 0;
    wr(REG_PROX_CTRL, 24'h0c0000, 1, 1'b1);
    chk("current", {1'b0, led_current_ma}, 8'h60);
    repeat (3 * PER + 100) @(posedge clk_sys);
    chk("pulses", npulse[7:0], 8'h03);
    chk("flag", {7'h0, prox_flag}, 8'h01);
    rd(REG_PROX_STATUS, 1);
    chk("status", {7'h0, q[0][7]}, 8'h01);
    rd(REG_PROX_TIMING, 2);
    chk("cycle pulse", q[0], 8'h11);
    chk("threshold", q[1], 8'h20);
    echo_level <= 8'h1f;
    repeat (2 * (3 * PER + CYC)) @(posedge clk_sys);
    chk("flag low", {7'h0, prox_flag}, 8'h00);
    // Largest pulse count and top current first, then random codes
    for (int k = 0; k < 2; k++) begin
      dc = k ? 4'($unsigned($random(seed)) % 12 + 1) : 4'hc;
      pc = k ? 4'($unsigned($random(seed)) % 15 + 1) : 4'hf;
      echo_level <= 8'h20 | 8'($random(seed));
      wr(REG_PROX_CTRL, {4'h8, dc, 4'h1, pc, 8'h20}, 3, 1'b0);
      npulse = 0;
      wr(REG_PROX_CTRL, {4'h0, dc, 16'h0}, 1, 1'b1);
      chk("current", {1'b0, led_current_ma}, 8'(dc * MA_PER_CODE));
      repeat (pc * 3 * PER + 100) @(posedge clk_sys);
      chk("pulses", npulse[7:0], 8'(pc * PULSES_PER_CODE));
      chk("flag", {7'h0, prox_flag}, 8'h01);
    end
    rd(REG_RED_HI, 8);
    for (int i = 0; i < 8; i++) chk("colour", q[i], color_data[63 - 8 * i -: 8]);
    wr(REG_PROX_CTRL, 24'hcc0000, 1, 1'b1);
    npulse = 0;
    repeat (3000) @(posedge clk_sys);
    chk("asleep", npulse[7:0], 8'h00);
    rd(REG_PROX_CTRL, 1);
    chk("ctrl", q[0], 8'hcc);
    finish_test();
  end
endmodule
bind pxs_top pxs_chk chk (.clk_sys(clk_sys), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .color_data(color_data), .echo_level(echo_level),
  .prox_pulse(prox_pulse), .led_current_ma(led_current_ma), .prox_flag(prox_flag));
